// >>> hw/tape_mark_defines.svh
// constants for the block mark writer: register map, fields, reset values
// assumes a 32-bit ahb-lite register port, word aligned
`ifndef TAPE_MARK_DEFINES_SVH
`define TAPE_MARK_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define TM_CTRL_OFFSET      8'h00
`define TM_STATUS_OFFSET    8'h04
`define TM_ADDR_BITS        8

// ****************************************
// command register fields
// ****************************************
`define TM_CTRL_FCN_LSB     0
`define TM_CTRL_FCN_MSB     2
`define TM_CTRL_REV_BIT     3
`define TM_CTRL_DELAY_BIT   4
`define TM_CTRL_RESET       5'h00

// function codes, the top bit marks a write
`define TM_FCN_WRITE_MARK   3'h5
`define TM_FCN_WRITE_TIMING 3'h7

// ****************************************
// status register fields
// ****************************************
`define TM_STAT_STATE_LSB   0
`define TM_STAT_TOGGLE_BIT  3
`define TM_STAT_DONE_BIT    4
`define TM_STAT_LOCK_BIT    5
`define TM_STAT_WREN_BIT    6
`define TM_STAT_SHIFT_LSB   8

// ****************************************
// timing
// ****************************************
`define TM_DELAY_CYCLES     1000
`define TM_SET_LATE_CYCLES  2

`endif

// >>> hw/tape_mark_pkg.sv
// types shared by the block mark writer modules
// needs no defines header; its encodings are written as literals
package tape_mark_pkg;

    // transmission controller, one-hot
    typedef enum logic [2:0]
    {
        XFER_NULL   = 3'b001,
        XFER_WAIT   = 3'b010,
        XFER_ACTIVE = 3'b100
    } xfer_state_t;

    // per-bit strobes, one cycle each
    typedef struct packed
    {
        logic zero;
        logic one;
        logic two;
        logic three;
        logic four;
    } time_pulses_t;

    // decoded mark track codes from the decoder pins
    typedef struct packed
    {
        logic sync;
        logic space;
        logic finish;
    } mark_codes_t;

    // the two ends of the data accumulator
    typedef struct packed
    {
        logic [5:0] left_char;
        logic [5:0] right_char;
    } dc_chars_t;

endpackage

// >>> hw/time_pulse_gen.sv
// time pulse chain: one ordered burst of five strobes per rising timing track edge
// assumes the timing track is a raw pin, asynchronous to hclk
`timescale 1ns/100ps
`default_nettype none

module time_pulse_gen
    import tape_mark_pkg::*;
(
    // clock and reset
    input  wire logic   hclk,
    input  wire logic   hresetn,
    // timing track
    input  wire logic   timing_track,
    // strobes
    output var time_pulses_t tp
);

    logic       track_meta_reg;
    logic       track_sync_reg;
    logic       track_prev_reg;
    logic [4:0] chain_reg;

    // ****************************************
    // synchroniser and chain
    // ****************************************

    // two flops before any logic reads the pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            track_meta_reg <= 1'b0;
            track_sync_reg <= 1'b0;
            track_prev_reg <= 1'b0;
        end
        else
        begin
            track_meta_reg <= timing_track;
            track_sync_reg <= track_meta_reg;
            track_prev_reg <= track_sync_reg;
        end
    end

    // rising edge starts the chain; a new edge mid-chain starts a second burst behind the first
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            chain_reg <= 5'h00;
        else
            chain_reg <= {chain_reg[3:0], track_sync_reg & ~track_prev_reg};
    end

    assign tp = '{zero: chain_reg[0], one: chain_reg[1], two: chain_reg[2],
                  three: chain_reg[3], four: chain_reg[4]};

endmodule

`default_nettype wire

// >>> hw/mark_position_shifter.sv
// block mark timing register: four stages stepped by mark codes at tp2
// assumes codes and strobe are synchronous to hclk
`timescale 1ns/100ps
`default_nettype none

module mark_position_shifter
    import tape_mark_pkg::*;
#(
    parameter int STAGES = 4
)
(
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // stepping
    input  wire logic              step,
    input  wire mark_codes_t       codes,
    // state
    output logic [STAGES-1:0]      stages,
    output logic                   last_entered
);

    logic shift_en;

    // only sync or space move the register
    assign shift_en = step & (codes.sync | codes.space);

    // a one enters on sync; four spaces push it out again
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stages <= '0;
        else if (shift_en)
            stages <= {stages[STAGES-2:0], codes.sync};
    end

    // the one is about to land in the last stage
    assign last_entered = shift_en & stages[STAGES-2] & ~stages[STAGES-1];

endmodule

`default_nettype wire

// >>> hw/tape_mark_writer.sv
// block mark writer: command register, transmission control, write path
// assumes ahb-lite master, data control logic on hclk, tape pins asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "tape_mark_defines.svh"

module tape_mark_writer
    import tape_mark_pkg::*;
#(
    parameter int DELAY_CYCLES = `TM_DELAY_CYCLES
)
(
    // ahb-lite slave
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // tape pins
    input  wire logic        timing_track,
    input  wire mark_codes_t mark_codes_pin,
    input  wire logic        write_lock_open,
    output logic [2:0]       head_write_buffer,
    output logic             write_current_gate,
    output logic             write_locked_level,
    // data control
    input  wire dc_chars_t   dc_chars,
    input  wire logic        data_timing_clear,
    output logic             dc_load,
    output logic             dc_shift_right
);

    // ****************************************
    // declarations
    // ****************************************
    logic [31:0]      ctrl_reg;
    logic             wr_pend_reg;
    logic [7:0]       addr_reg;
    logic             command_clear_pulse;
    logic [1:0]       set_late_reg;
    logic             command_set_late_pulse;
    logic             delay_running;
    logic [31:0]      delay_cnt_reg;
    logic             delay_prev_reg;
    mark_codes_t      codes_meta_reg;
    mark_codes_t      codes_reg;
    logic             lock_meta_reg;
    logic             lock_reg;
    time_pulses_t     tp;
    logic [3:0]       mark_position_shifter_q;
    logic             last_entered;
    xfer_state_t      state_reg;
    logic             byte_half_toggle;
    logic [5:0]       char_buffer;
    logic             mark_end_seen;
    logic             job_finished_flag;
    logic             job_prev_reg;
    logic             write_current_flop;
    logic             function_bit_high;
    logic             delay_requested;
    logic             reverse;
    logic             active;
    logic             odd_half;
    logic             writing;
    logic [2:0]       half_sel;

    // read mux shared by the address phase
    function automatic logic [31:0] read_word(input logic [7:0] a, input logic [31:0] ctrl,
                                              input logic [31:0] stat);
        if (a == `TM_CTRL_OFFSET)
            read_word = ctrl;
        else if (a == `TM_STATUS_OFFSET)
            read_word = stat;
        else
            read_word = 32'h0000_0000;
    endfunction

    // ****************************************
    // register port
    // ****************************************

    // zero wait states; every answer is okay, unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout   <= 1'b0;
            hresp       <= 1'b0;
            wr_pend_reg <= 1'b0;
            addr_reg    <= 8'h00;
            hrdata      <= 32'h0000_0000;
        end
        else
        begin
            hreadyout   <= 1'b1;
            wr_pend_reg <= hsel & htrans[1] & hwrite & hready;
            if (hsel & htrans[1] & hready)
                addr_reg <= haddr[`TM_ADDR_BITS-1:0];
            if (hsel & htrans[1] & hready & ~hwrite)
                hrdata <= read_word(haddr[`TM_ADDR_BITS-1:0], ctrl_reg,
                                    {16'h0000, 4'h0, mark_position_shifter_q, 1'b0,
                                     write_current_flop, lock_reg, job_finished_flag,
                                     byte_half_toggle, state_reg});
        end
    end

    // a command write clears and loads the new command on the same pulse
    assign command_clear_pulse = wr_pend_reg & (addr_reg == `TM_CTRL_OFFSET);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctrl_reg <= 32'h0000_0000;
        else if (command_clear_pulse)
            ctrl_reg <= {27'h000_0000, hwdata[4:0]};
    end

    assign function_bit_high = ctrl_reg[`TM_CTRL_FCN_MSB];
    assign reverse           = ctrl_reg[`TM_CTRL_REV_BIT];
    assign delay_requested   = ctrl_reg[`TM_CTRL_DELAY_BIT];

    // late set pulse: acts on its trailing edge, a few cycles after the write
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            set_late_reg <= 2'b00;
        else
            set_late_reg <= {set_late_reg[0], command_clear_pulse};
    end
    assign command_set_late_pulse = set_late_reg[1];

    // initial delay; counted in hclk cycles
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            delay_cnt_reg <= 32'h0000_0000;
        else if (command_set_late_pulse & delay_requested)
            delay_cnt_reg <= 32'(DELAY_CYCLES);
        else if (command_clear_pulse)
            delay_cnt_reg <= 32'h0000_0000;
        else if (delay_running)
            delay_cnt_reg <= delay_cnt_reg - 32'h0000_0001;
    end
    assign delay_running = (delay_cnt_reg != 32'h0000_0000);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            delay_prev_reg <= 1'b0;
        else
            delay_prev_reg <= delay_running;
    end

    // ****************************************
    // pins and timing
    // ****************************************

    // mark codes and lock switch are tape pins: two flops each
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            codes_meta_reg <= '0;
            codes_reg      <= '0;
            lock_meta_reg  <= 1'b0;
            lock_reg       <= 1'b0;
        end
        else
        begin
            codes_meta_reg <= mark_codes_pin;
            codes_reg      <= codes_meta_reg;
            lock_meta_reg  <= write_lock_open;
            lock_reg       <= lock_meta_reg;
        end
    end

    time_pulse_gen u_time_pulse_gen
    (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .timing_track (timing_track),
        .tp           (tp)
    );

    mark_position_shifter #(.STAGES(4)) u_mark_position_shifter
    (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .step         (tp.two),
        .codes        (codes_reg),
        .stages       (mark_position_shifter_q),
        .last_entered (last_entered)
    );

    // ****************************************
    // transmission controller
    // ****************************************
    assign active   = (state_reg == XFER_ACTIVE);
    assign odd_half = active & ~byte_half_toggle;
    assign writing  = function_bit_high & (active | write_current_flop);

    // clear wins over everything; flag edge ends the block
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_reg <= XFER_NULL;
        else if (command_clear_pulse)
            state_reg <= XFER_NULL;
        else if (job_finished_flag & ~job_prev_reg)
            state_reg <= XFER_NULL;
        else if (state_reg == XFER_NULL)
        begin
            if (command_set_late_pulse & ~delay_requested)
                state_reg <= XFER_WAIT;
            else if (delay_prev_reg & ~delay_running)
                state_reg <= XFER_WAIT;
        end
        else if (state_reg == XFER_WAIT)
        begin
            if (last_entered & (ctrl_reg[2:0] == `TM_FCN_WRITE_MARK))
                state_reg <= XFER_ACTIVE;
        end
    end

    // toggle only flips when already active before this tp2
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            byte_half_toggle <= 1'b0;
        else if (!active)
            byte_half_toggle <= 1'b0;
        else if (tp.two)
            byte_half_toggle <= ~byte_half_toggle;
    end

    // ****************************************
    // character path
    // ****************************************

    // clear at tp3, refill at tp4, both on the odd half only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            char_buffer <= 6'h00;
        else if (tp.three & odd_half)
            char_buffer <= 6'h00;
        else if (tp.four & odd_half & data_timing_clear & (ctrl_reg[2:0] != `TM_FCN_WRITE_TIMING))
            char_buffer <= reverse ? dc_chars.right_char : dc_chars.left_char;
    end

    // load pulse lets the data control start the next character
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dc_load        <= 1'b0;
            dc_shift_right <= 1'b0;
        end
        else
        begin
            dc_load        <= tp.four & odd_half & data_timing_clear
                              & (ctrl_reg[2:0] != `TM_FCN_WRITE_TIMING);
            dc_shift_right <= reverse;
        end
    end

    // toggle zero writes the upper half first
    assign half_sel = byte_half_toggle ? char_buffer[2:0] : char_buffer[5:3];

    // reverse writes the complement so a forward read needs no fixing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            head_write_buffer <= 3'h0;
        else if (tp.zero & writing)
            head_write_buffer <= reverse ? ~half_sel : half_sel;
        else if (tp.one & writing)
            head_write_buffer <= ~head_write_buffer;
    end

    // ****************************************
    // end of block and write current
    // ****************************************

    // end code latched at tp1, flag set at the next tp2
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mark_end_seen     <= 1'b0;
            job_finished_flag <= 1'b0;
            job_prev_reg      <= 1'b0;
        end
        else
        begin
            job_prev_reg <= job_finished_flag;
            if (command_clear_pulse)
                mark_end_seen <= 1'b0;
            else if (tp.one)
                mark_end_seen <= codes_reg.finish & active;
            if (tp.two & mark_end_seen)
                job_finished_flag <= 1'b1;
            else if (command_clear_pulse)
                job_finished_flag <= 1'b0;
        end
    end

    // held until tp4 so the last half still gets written
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            write_current_flop <= 1'b0;
        else if (tp.zero & active)
            write_current_flop <= 1'b1;
        else if (tp.four & ~active)
            write_current_flop <= 1'b0;
    end

    // interlock with the transport's lock switch
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            write_current_gate <= 1'b0;
            write_locked_level <= 1'b0;
        end
        else
        begin
            write_current_gate <= function_bit_high & write_current_flop & ~lock_reg;
            write_locked_level <= lock_reg;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_clear_cmd;
        command_clear_pulse;
    endsequence

    sequence s_end_then_tp2;
        tp.one & codes_reg.finish & active & ~command_clear_pulse ##1 tp.two;
    endsequence

    AST_CLEAR_NULL: assert property (@(posedge hclk) disable iff (!hresetn)
        s_clear_cmd |=> state_reg == XFER_NULL)
        else $error("command clear did not force null");

    AST_NO_DELAY_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        command_set_late_pulse & ~delay_requested & state_reg == XFER_NULL & ~command_clear_pulse
        & ~(job_finished_flag & ~job_prev_reg) |=> state_reg == XFER_WAIT)
        else $error("late set did not reach wait");

    AST_ACTIVE_CAUSE: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(active) |-> $past(last_entered) & $past(state_reg) == XFER_WAIT)
        else $error("active entered without last stage");

    AST_TOGGLE_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
        !active |=> !byte_half_toggle)
        else $error("toggle not held at zero");

    AST_TOGGLE_FLIP: assert property (@(posedge hclk) disable iff (!hresetn)
        active & tp.two & ~command_clear_pulse & ~(job_finished_flag & ~job_prev_reg)
        |=> byte_half_toggle != $past(byte_half_toggle))
        else $error("toggle failed to flip");

    AST_CLEAR_TP3: assert property (@(posedge hclk) disable iff (!hresetn)
        tp.three & odd_half |=> char_buffer == 6'h00)
        else $error("buffer not cleared at tp3");

    AST_LOAD_TP4: assert property (@(posedge hclk) disable iff (!hresetn)
        dc_load |-> $past(tp.four) & $past(odd_half))
        else $error("load pulse outside tp4 odd half");

    AST_DONE_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        s_end_then_tp2 ##0 ~command_clear_pulse |=> job_finished_flag)
        else $error("finished flag not set after end mark");

    AST_WREN_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        write_current_flop & ~tp.four |=> write_current_flop)
        else $error("write flop dropped before tp4");

    AST_LOCK_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_reg |=> !write_current_gate ##0 write_locked_level)
        else $error("write current with lock open");

endmodule

`default_nettype wire

// >>> sim/data_control_model.sv
// data control stand-in: accumulator ends, rotating on each load
// assumes loads arrive as one-cycle pulses on hclk
`timescale 1ns/100ps
`default_nettype none

module data_control_model
    import tape_mark_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // from the writer
    input  wire logic dc_load,
    input  wire logic dc_shift_right,
    // accumulator ends
    output var dc_chars_t dc_chars
);
    logic [35:0] acc_reg;

    // rotate rather than shift, so the ends never settle to a constant
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            acc_reg <= 36'h9_1a2b_3c4d;
        else if (dc_load)
            acc_reg <= dc_shift_right ? {acc_reg[5:0], acc_reg[35:6]} : {acc_reg[29:0], acc_reg[35:30]};
    end

    // both ends always on offer, the writer picks one
    assign dc_chars = '{left_char: acc_reg[35:30], right_char: acc_reg[5:0]};
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// bench for the block mark writer: ahb-lite master, tape stimulus, checks
// assumes the data control model on the far side and one 125 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "tape_mark_defines.svh"

`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin miscompares++; \
    $display("Error %s expected %h seen %h", n, e, s); end end

module tb_top;
    import tape_mark_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, head_write_buffer;
    logic        timing_track, write_lock_open, data_timing_clear;
    logic        write_current_gate, write_locked_level, dc_load, dc_shift_right;
    mark_codes_t mark_codes_pin;
    dc_chars_t   dc_chars;
    int          miscompares, comparisons, loads;

    tape_mark_writer #(.DELAY_CYCLES(10)) i_tape_mark_writer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timing_track(timing_track),
        .mark_codes_pin(mark_codes_pin), .write_lock_open(write_lock_open), .head_write_buffer(head_write_buffer),
        .write_current_gate(write_current_gate), .write_locked_level(write_locked_level), .dc_chars(dc_chars),
        .data_timing_clear(data_timing_clear), .dc_load(dc_load), .dc_shift_right(dc_shift_right));
    data_control_model i_data_control_model (.hclk(hclk), .hresetn(hresetn), .dc_load(dc_load),
        .dc_shift_right(dc_shift_right), .dc_chars(dc_chars));

    // ****************************************
    // clock, counters and bus tasks
    // ****************************************
    initial
    begin
        hclk = 0;
        forever #4 hclk = ~hclk;
    end

    // loads are pulses, so count them at the edge
    always @(posedge hclk)
        if (dc_load === 1'b1) loads++;

    // one single word transfer, address phase held until ready
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    begin
        hsel <= 1; haddr <= a; htrans <= 2'h2; hwrite <= w; hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    end
    endtask

    // one bit time of eight cycles with the given mark code held
    task bt(input mark_codes_t c);
    begin
        mark_codes_pin <= c; timing_track <= 1;
        @(posedge hclk);
        timing_track <= 0;
        repeat (7) @(posedge hclk);
    end
    endtask

    task give_verdict;
    begin
        if (miscompares == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    initial
    begin
        hresetn = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0; hwdata = 0;
        timing_track = 0; mark_codes_pin = '0; write_lock_open = 0; data_timing_clear = 1;
        miscompares = 0; comparisons = 0; loads = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1;
        repeat (2) @(posedge hclk);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("state", 32'h0000_0001, rd & 32'h0000_0f1f)
        `CHK("resp", 1'b0, hresp)
        xfer(0, 32'h0000_0008, 0); `CHK("unmapped", 32'h0000_0000, rd)
        // delayed start stays null until the delay runs out
        xfer(1, `TM_CTRL_OFFSET, 32'h0000_0015);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("delay null", 32'h0000_0001, rd & 32'h0000_0007)
        repeat (20) @(posedge hclk);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("delay wait", 32'h0000_0002, rd & 32'h0000_0007)
        // plain start: wait, then sync and spaces every two bit times
        xfer(1, `TM_CTRL_OFFSET, 32'h0000_0005);
        repeat (4) @(posedge hclk);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("wait", 32'h0000_0002, rd & 32'h0000_0f0f)
        bt(3'b100); bt(3'b000);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("sync", 32'h0000_0102, rd & 32'h0000_0f07)
        bt(3'b010); bt(3'b000); bt(3'b010); bt(3'b000);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("two spaces", 32'h0000_0402, rd & 32'h0000_0f07)
        loads = 0;
        bt(3'b010);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("active", 32'h0000_0804, rd & 32'h0000_0f0f)
        bt(3'b000); bt(3'b010); bt(3'b000);
        // second character 6'h1a: upper half 3'b011, flipped at tp1
        `CHK("head fwd", 3'b100, head_write_buffer)
        `CHK("loads", 2, loads)
        `CHK("gate on", 1'b1, write_current_gate)
        // lock switch opened mid-block
        write_lock_open <= 1;
        repeat (8) @(posedge hclk);
        `CHK("locked", 1'b1, write_locked_level)
        `CHK("gate off", 1'b0, write_current_gate)
        write_lock_open <= 0;
        // mark end closes the block
        bt(3'b001); bt(3'b000);
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("done", 32'h0000_0011, rd & 32'h0000_001f)
        `CHK("gate end", 1'b0, write_current_gate)
        // reverse motion asks the data control to shift right
        xfer(1, `TM_CTRL_OFFSET, 32'h0000_000d);
        repeat (4) @(posedge hclk);
        `CHK("reverse", 1'b1, dc_shift_right)
        xfer(0, `TM_STATUS_OFFSET, 0); `CHK("cleared", 32'h0000_0002, rd & 32'h0000_0017)
        // reverse block: right end 6'h1a, upper half complemented at tp0, flipped back at tp1
        bt(3'b100); bt(3'b000); bt(3'b010); bt(3'b000);
        bt(3'b010); bt(3'b000); bt(3'b010); bt(3'b000);
        `CHK("head rev", 3'b011, head_write_buffer)
        give_verdict;
    end

    // cut a hang short well past the expected run
    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        give_verdict;
    end
endmodule

`default_nettype wire
